// ==== verilog/oscdz_osc_ctrl.sv ====
// oscillator selection, secondary oscillator, doze and fast RC postscaler/trim control
// Summary of operation
// [RL1] current source is a read-only 3-bit field updated by hardware
// [RL2] writable 3-bit requested source, same encodings, used at next switch
// [RL3] requested source resets from the initial-source configuration setting
// [RL4] with fail-safe monitor on, a set selection lock blocks switching; software sets only
// [RL5] with fail-safe monitor off, selections never lock
// [RL6] pll lock flag is one when locked or start-up timer expired; the code has no start-up timer and follows the synchronised i_pll_locked only
// [RL7] pll lock flag clears on each valid switch and in non-pll modes
// [RL8] clock-fail flag set by the monitor, cleared only by software, resets zero
// [RL9] drive bit one picks high-power secondary; else config; ignored for digital input
// [RL10] secondary oscillator runs while its enable is one or otherwise required
// [RL11] software sets switch request; it reads zero once the switch completes
// [RL12] with recover-on-interrupt set, interrupts clear doze enable and restore 1:1
// [RL13] doze field picks cpu ratio 1:1 to 1:128 while doze enabled, else 1:1
// [RL14] interrupt with recover-on-interrupt set clears doze enable
// [RL15] sources 111 and 001 divide the 8 MHz fast RC by the postscaler code
// [RL16] source 110 applies the postscaler to the 500 kHz fast RC
// [RL17] signed 6-bit fast RC trim field, resets to zero
// [RL18] unimplemented bits read zero and ignore writes
// [RL19] switch to the current source is aborted and the request cleared
// [RL20] valid switch waits ready plus 10 new-source cycles, then commits
// [RL21] software unlocks each byte of the control register with a two-write key
// [RL22] with switching disabled, request held zero and requested source ignored
// [RL23] clock-fail stays set until cleared; writing one does nothing
//
// The implementer's own choices: the register addresses and the plain strobed port.
`include "oscdz_defines.svh"
module oscdz_osc_ctrl (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic [1:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_write,
	input  wire logic        i_read,
	output logic      [31:0] o_rdata,
	input  wire logic [2:0]  i_initial_source_cfg,
	input  wire logic        i_switch_monitor_cfg_n,
	input  wire logic        i_failsafe_monitor_cfg_n,
	input  wire logic        i_secondary_input_cfg,
	input  wire logic        i_secondary_power_cfg,
	input  wire logic        i_pll_locked,
	input  wire logic        i_failsafe_monitor_fail,
	input  wire logic        i_new_source_ready,
	input  wire logic        i_new_source_clk,
	input  wire logic        i_secondary_required,
	input  wire logic        i_interrupt,
	output logic      [2:0]  o_current_source_sel,
	output logic             o_secondary_osc_enable,
	output logic             o_secondary_high_power,
	output logic      [2:0]  o_cpu_doze_ratio,
	output logic      [2:0]  o_fast_rc_postscale,
	output logic             o_fast_rc_divided_on,
	output logic             o_slow_fast_rc_divided_on,
	output logic      [5:0]  o_fast_rc_trim,
	output logic             o_switch_busy
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [4:0] pins_sync;
	logic       new_clk_prev;

	oscdz_sync #(.WIDTH(5)) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_pll_locked, i_failsafe_monitor_fail, i_new_source_ready, i_new_source_clk,
			i_interrupt}),
		.o_sync  (pins_sync)
	);

	wire logic pll_locked_s   = pins_sync[4];
	wire logic fail_s         = pins_sync[3];
	wire logic new_ready_s    = pins_sync[2];
	wire logic new_clk_s      = pins_sync[1];
	wire logic interrupt_s    = pins_sync[0];
	// the new-source clock is edge-detected only after the second flop
	wire logic new_clk_edge   = new_clk_s && !new_clk_prev;

	////////////////////////////////////////////////////////////////////////////
	// configuration capture after reset release

	// config straps are static levels and skip the synchroniser
	logic       cfg_loaded;
	logic       cfg_switch_en;
	logic       cfg_monitor_en;
	wire  logic cfg_load = !cfg_loaded;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cfg_loaded <= 1'b0;
		end else begin
			cfg_loaded <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (cfg_load) begin
			cfg_switch_en  <= !i_switch_monitor_cfg_n;
			cfg_monitor_en <= !i_switch_monitor_cfg_n && !i_failsafe_monitor_cfg_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus decode and unlock keys

	function automatic logic is_pll_source(input logic [2:0] src);
		return src == `OSCDZ_SRC_FAST_RC_MULTIPLIED || src == `OSCDZ_SRC_PRIPLL;
	endfunction

	wire logic wr_ctrl  = i_write && i_addr == `OSCDZ_OFF_OSC_CTRL;
	wire logic wr_div   = i_write && i_addr == `OSCDZ_OFF_CLK_DIV;
	wire logic wr_tune  = i_write && i_addr == `OSCDZ_OFF_RC_TUNE;
	wire logic wr_hi    = wr_ctrl && i_wdata[`OSCDZ_KEY_HI_BIT];
	wire logic wr_lo    = wr_ctrl && i_wdata[`OSCDZ_KEY_LO_BIT];
	wire logic [7:0] wb_hi = i_wdata[15:8];
	wire logic [7:0] wb_lo = i_wdata[7:0];

	// two-write unlock: the first key byte arms, the second opens, anything else closes
	function automatic logic [1:0] key_step(input logic lane, input logic [7:0] data, input logic [1:0] key,
		input logic [7:0] key_a, input logic [7:0] key_b);
		logic [1:0] step;
		step = 2'h0;
		if (lane && data == key_a) begin
			step = 2'h1;
		end else if (lane && key == 2'h1 && data == key_b) begin
			step = 2'h2;
		end
		return step;
	endfunction

	logic [1:0] hi_key;
	logic [1:0] lo_key;
	wire  logic       hi_open     = hi_key == 2'h2;
	wire  logic       lo_open     = lo_key == 2'h2;
	wire  logic [1:0] next_hi_key = key_step(wr_hi, wb_hi, hi_key, `OSCDZ_KEY_HI_A, `OSCDZ_KEY_HI_B);
	wire  logic [1:0] next_lo_key = key_step(wr_lo, wb_lo, lo_key, `OSCDZ_KEY_LO_A, `OSCDZ_KEY_LO_B);

	// keys expire on any other register write so the unlock is back-to-back only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			hi_key <= 2'h0;
			lo_key <= 2'h0;
		end else if (i_write) begin
			hi_key <= next_hi_key; // RL21
			lo_key <= next_lo_key; // RL21
		end
	end

	wire logic hi_commit = wr_hi && hi_open;
	wire logic lo_commit = wr_lo && lo_open;

	////////////////////////////////////////////////////////////////////////////
	// switch sequencer

	oscdz_switch_if sw ();

	logic [2:0] next_source_sel;
	logic       selection_lock;
	logic       switch_request;
	logic       pll_lock_flag;
	logic       clock_fail_flag;
	logic       secondary_drive_sel;
	logic       secondary_osc_enable;

	// the lock only bites while the fail-safe monitor is configured on
	wire logic locked_out = cfg_monitor_en && selection_lock; // RL4 RL5
	wire logic req_set    = lo_commit && i_wdata[`OSCDZ_SWREQ_BIT] && cfg_switch_en && !locked_out;

	// start stays off while busy; a redundant request closes itself through done
	assign sw.start  = switch_request && !sw.busy;
	assign sw.target = next_source_sel;

	oscdz_switch_seq u_seq (
		.i_clk          (i_clk),
		.i_reset        (i_reset),
		.i_cfg_load     (cfg_load),
		// straps are read at the load edge itself, so a one-edge reset still captures them
		.i_cfg_source   (i_initial_source_cfg),
		.i_new_ready    (new_ready_s),
		.i_new_clk_edge (new_clk_edge),
		.sw             (sw)
	);

	////////////////////////////////////////////////////////////////////////////
	// oscillator control register

	// a new target is refused mid-switch so the commit copies what was compared
	always_ff @(posedge i_clk) begin
		if (cfg_load) begin
			next_source_sel <= i_initial_source_cfg; // RL3
		end else if (hi_commit && !locked_out && cfg_switch_en && !sw.busy) begin
			next_source_sel <= i_wdata[`OSCDZ_NEXT_MSB:`OSCDZ_NEXT_LSB]; // RL2 RL22
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			selection_lock       <= 1'b0;
			switch_request       <= 1'b0;
			pll_lock_flag        <= 1'b0;
			clock_fail_flag      <= 1'b0;
			secondary_drive_sel  <= 1'b0;
			secondary_osc_enable <= 1'b0;
			new_clk_prev         <= 1'b0;
		end else begin
			new_clk_prev <= new_clk_s;
			if (lo_commit && i_wdata[`OSCDZ_SELLOCK_BIT]) begin
				selection_lock <= 1'b1; // RL4
			end
			if (!cfg_switch_en || sw.done) begin
				switch_request <= 1'b0; // RL11 RL19 RL22
			end else if (req_set) begin
				switch_request <= 1'b1; // RL11
			end
			// drops the cycle a valid switch starts and stays low on sources without the pll
			pll_lock_flag <= pll_locked_s && !sw.pll_clear && is_pll_source(sw.current); // RL6 RL7
			if (fail_s) begin
				clock_fail_flag <= 1'b1; // RL8 RL23
			end else if (lo_commit && !i_wdata[`OSCDZ_FAIL_BIT]) begin
				clock_fail_flag <= 1'b0; // RL23
			end
			if (lo_commit) begin
				secondary_drive_sel  <= i_wdata[`OSCDZ_DRIVE_BIT];
				secondary_osc_enable <= i_wdata[`OSCDZ_SECONDARY_OSC_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock divider and tune registers

	logic       recover_on_interrupt;
	logic [2:0] doze_ratio;
	logic       doze_enable;
	logic [2:0] fast_rc_postscale;
	logic [5:0] fast_rc_trim;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			recover_on_interrupt <= 1'b0;
			doze_ratio           <= `OSCDZ_DOZE_RESET;
			doze_enable          <= 1'b0;
			fast_rc_postscale    <= `OSCDZ_FAST_RC_POSTSCALE_RESET;
			fast_rc_trim         <= `OSCDZ_TRIM_RESET; // RL17
		end else begin
			if (wr_div) begin
				recover_on_interrupt <= i_wdata[`OSCDZ_ROI_BIT];
				doze_ratio           <= i_wdata[`OSCDZ_DOZE_MSB:`OSCDZ_DOZE_LSB];
				fast_rc_postscale    <= i_wdata[`OSCDZ_FAST_RC_POSTSCALE_MSB:`OSCDZ_FAST_RC_POSTSCALE_LSB];
			end
			// interrupt recovery wins over a simultaneous software set
			if (interrupt_s && recover_on_interrupt) begin
				doze_enable <= 1'b0; // RL12 RL14
			end else if (wr_div) begin
				doze_enable <= i_wdata[`OSCDZ_DOZE_ENABLE_BIT];
			end
			if (wr_tune) begin
				fast_rc_trim <= i_wdata[`OSCDZ_TRIM_MSB:0]; // RL17
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data and outputs

	wire logic [31:0] rd_ctrl = {17'h0, sw.current, 1'b0, next_source_sel, selection_lock, 1'b0,
		pll_lock_flag, 1'b0, clock_fail_flag, secondary_drive_sel, secondary_osc_enable,
		switch_request}; // RL1 RL18
	wire logic [31:0] rd_div  = {16'h0000, recover_on_interrupt, doze_ratio, doze_enable, fast_rc_postscale,
		8'h00}; // RL18
	wire logic [31:0] rd_tune = {26'h0, fast_rc_trim}; // RL18
	wire logic [31:0] rd_stat = {30'h0, lo_open, hi_open};
	wire logic [31:0] rd_mux  = (i_addr == `OSCDZ_OFF_OSC_CTRL) ? rd_ctrl :
		(i_addr == `OSCDZ_OFF_CLK_DIV) ? rd_div :
		(i_addr == `OSCDZ_OFF_RC_TUNE) ? rd_tune : rd_stat;
	wire logic        cur_fast_div = sw.current == `OSCDZ_SRC_FAST_RC_DIVIDED || sw.current == `OSCDZ_SRC_FAST_RC_MULTIPLIED; // RL15
	wire logic        cur_slow_div = sw.current == `OSCDZ_SRC_SLOW_FAST_RC_DIVIDED; // RL16

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata                   <= 32'h00000000;
			o_current_source_sel      <= 3'h0;
			o_secondary_osc_enable    <= 1'b0;
			o_secondary_high_power    <= 1'b0;
			o_cpu_doze_ratio          <= 3'h0;
			o_fast_rc_postscale       <= `OSCDZ_FAST_RC_POSTSCALE_RESET;
			o_fast_rc_divided_on      <= 1'b0;
			o_slow_fast_rc_divided_on <= 1'b0;
			o_fast_rc_trim            <= `OSCDZ_TRIM_RESET;
			o_switch_busy             <= 1'b0;
		end else begin
			// read data fall back to zero outside the answer cycle
			o_rdata                   <= i_read ? rd_mux : 32'h00000000;
			o_current_source_sel      <= sw.current; // RL1
			o_secondary_osc_enable    <= secondary_osc_enable || i_secondary_required; // RL10
			// a digital secondary input ignores the drive bit and stays low power
			o_secondary_high_power    <= i_secondary_input_cfg &&
				(secondary_drive_sel || i_secondary_power_cfg); // RL9
			o_cpu_doze_ratio          <= doze_enable ? doze_ratio : 3'h0; // RL13
			o_fast_rc_postscale       <= fast_rc_postscale;
			o_fast_rc_divided_on      <= cur_fast_div; // RL15
			o_slow_fast_rc_divided_on <= cur_slow_div; // RL16
			o_fast_rc_trim            <= fast_rc_trim;
			o_switch_busy             <= sw.busy;
		end
	end
endmodule

// ==== verilog/oscdz_defines.svh ====
// register offsets, field positions, reset values and timing counts for the oscillator control block
`ifndef OSCDZ_DEFINES_SVH
`define OSCDZ_DEFINES_SVH

`define OSCDZ_ADDR_W          2
`define OSCDZ_OFF_OSC_CTRL    2'h0
`define OSCDZ_OFF_CLK_DIV     2'h1
`define OSCDZ_OFF_RC_TUNE     2'h2
`define OSCDZ_OFF_STATUS      2'h3

`define OSCDZ_KEY_HI_A        8'h78
`define OSCDZ_KEY_HI_B        8'h9A
`define OSCDZ_KEY_LO_A        8'h46
`define OSCDZ_KEY_LO_B        8'h57
`define OSCDZ_KEY_HI_BIT      16
`define OSCDZ_KEY_LO_BIT      17

`define OSCDZ_CUR_MSB         14
`define OSCDZ_CUR_LSB         12
`define OSCDZ_NEXT_MSB        10
`define OSCDZ_NEXT_LSB        8
`define OSCDZ_SELLOCK_BIT     7
`define OSCDZ_PLLLOCK_BIT     5
`define OSCDZ_FAIL_BIT        3
`define OSCDZ_DRIVE_BIT       2
`define OSCDZ_SECONDARY_OSC_EN_BIT     1
`define OSCDZ_SWREQ_BIT       0

`define OSCDZ_ROI_BIT         15
`define OSCDZ_DOZE_MSB        14
`define OSCDZ_DOZE_LSB        12
`define OSCDZ_DOZE_ENABLE_BIT       11
`define OSCDZ_FAST_RC_POSTSCALE_MSB       10
`define OSCDZ_FAST_RC_POSTSCALE_LSB       8
`define OSCDZ_DOZE_RESET      3'h3
`define OSCDZ_FAST_RC_POSTSCALE_RESET     3'h1
`define OSCDZ_TRIM_MSB        5
`define OSCDZ_TRIM_RESET      6'h00

`define OSCDZ_SRC_FRC         3'h0
`define OSCDZ_SRC_FAST_RC_MULTIPLIED      3'h1
`define OSCDZ_SRC_PRIPLL      3'h3
`define OSCDZ_SRC_SLOW_FAST_RC_DIVIDED    3'h6
`define OSCDZ_SRC_FAST_RC_DIVIDED      3'h7

`define OSCDZ_SETTLE_CYCLES   4'hA
`define OSCDZ_SETTLE_W        4

`endif

// ==== verilog/oscdz_pkg.sv ====
// types shared by the oscillator control block
package oscdz_pkg;
	typedef logic [2:0] oscdz_src_t;
	typedef enum logic [1:0] {
		OSCDZ_IDLE,
		OSCDZ_WAIT_READY,
		OSCDZ_SETTLE
	} oscdz_sw_state_t;
endpackage

// ==== verilog/oscdz_switch_if.sv ====
// switch request and answer between the register file and the switch sequencer
interface oscdz_switch_if;
	logic                   start;
	oscdz_pkg::oscdz_src_t  target;
	logic                   done;
	logic                   busy;
	logic                   pll_clear;
	oscdz_pkg::oscdz_src_t  current;

	modport regs (output start, output target, input done, input busy, input pll_clear, input current);
	modport seq  (input start, input target, output done, output busy, output pll_clear, output current);
endinterface

// ==== verilog/oscdz_sync.sv ====
// two-flop synchroniser for a bundle of level inputs
module oscdz_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// ==== verilog/oscdz_switch_seq.sv ====
// clock switch sequencer: wait for the new source, count its settle cycles, commit
`include "oscdz_defines.svh"
module oscdz_switch_seq (
	input  wire logic      i_clk,
	input  wire logic      i_reset,
	input  wire logic      i_cfg_load,
	input  wire oscdz_pkg::oscdz_src_t i_cfg_source,
	input  wire logic      i_new_ready,
	input  wire logic      i_new_clk_edge,
	oscdz_switch_if.seq    sw
);
	oscdz_pkg::oscdz_sw_state_t state;
	oscdz_pkg::oscdz_sw_state_t next_state;
	logic [`OSCDZ_SETTLE_W-1:0] settle;
	logic [`OSCDZ_SETTLE_W-1:0] next_settle;
	wire logic redundant = sw.start && (sw.target == sw.current);

	assign sw.busy      = (state != oscdz_pkg::OSCDZ_IDLE);
	assign sw.done      = (state == oscdz_pkg::OSCDZ_SETTLE) && (next_settle == `OSCDZ_SETTLE_CYCLES)
		|| redundant; // RL19
	assign sw.pll_clear = sw.start && !redundant; // RL7

	always_comb begin
		next_state  = state;
		next_settle = settle;
		unique case (state)
			oscdz_pkg::OSCDZ_IDLE: begin
				if (sw.start && !redundant) begin
					next_state = oscdz_pkg::OSCDZ_WAIT_READY;
				end
			end
			oscdz_pkg::OSCDZ_WAIT_READY: begin
				next_settle = '0;
				if (i_new_ready) begin
					next_state = oscdz_pkg::OSCDZ_SETTLE; // RL20
				end
			end
			oscdz_pkg::OSCDZ_SETTLE: begin
				if (i_new_clk_edge) begin
					next_settle = settle + `OSCDZ_SETTLE_W'(1);
				end
				if (next_settle == `OSCDZ_SETTLE_CYCLES) begin
					next_state = oscdz_pkg::OSCDZ_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state  <= oscdz_pkg::OSCDZ_IDLE;
			settle <= '0;
		end else begin
			state  <= next_state;
			settle <= next_settle;
		end
	end

	// the current source is caught from the configuration after reset release
	always_ff @(posedge i_clk) begin
		if (i_cfg_load) begin
			sw.current <= i_cfg_source;
		end else if (state == oscdz_pkg::OSCDZ_SETTLE && next_state == oscdz_pkg::OSCDZ_IDLE) begin
			sw.current <= sw.target; // RL20
		end
	end
endmodule

// ==== bench/oscdz_osc_ctrl_assertions.sv ====
// concurrent checks on the oscillator control block ports
module oscdz_chk (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic [1:0]  i_addr,
	input wire logic        i_read,
	input wire logic [31:0] o_rdata,
	input wire logic        i_secondary_input_cfg,
	input wire logic [2:0]  o_current_source_sel,
	input wire logic        o_secondary_osc_enable,
	input wire logic        o_secondary_high_power,
	input wire logic [2:0]  o_cpu_doze_ratio,
	input wire logic [2:0]  o_fast_rc_postscale,
	input wire logic [5:0]  o_fast_rc_trim,
	input wire logic        o_switch_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rd_q;
	logic [1:0] ad_q;
	wire        r0 = rd_q && ad_q == 2'h0;
	wire        r1 = rd_q && ad_q == 2'h1;
	wire        r2 = rd_q && ad_q == 2'h2;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	always_ff @(posedge i_clk) begin
		rd_q <= i_read;
		ad_q <= i_addr;
	end
	////////////////////////////////////////////////////////////////
	chk_rd_upper: assert property (rd_q |-> o_rdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	chk_ctrl_gaps: assert property (r0 |-> {o_rdata[15], o_rdata[11], o_rdata[6], o_rdata[4]} == 4'h0)
		else $error("control gap bits not zero");
	chk_div_low: assert property (r1 |-> o_rdata[7:0] == 8'h00)
		else $error("divider low byte not zero");
	chk_cur_field: assert property (r0 && $stable(o_current_source_sel) |-> o_rdata[14:12] == o_current_source_sel)
		else $error("current source field differs from output");
	chk_doze_ratio: assert property (r1 && $stable(o_cpu_doze_ratio)
		|-> o_cpu_doze_ratio == (o_rdata[11] ? o_rdata[14:12] : 3'h0))
		else $error("doze ratio differs from divider fields");
	chk_post_out: assert property (r1 && $stable(o_fast_rc_postscale) |-> o_fast_rc_postscale == o_rdata[10:8])
		else $error("postscale output differs from field");
	chk_trim_out: assert property (r2 && $stable(o_fast_rc_trim)
		|-> o_fast_rc_trim == o_rdata[5:0] && o_rdata[15:6] == 10'h0)
		else $error("trim output differs from field");
	chk_secondary_osc_on: assert property (r0 && o_rdata[1] |-> ##[0:2] o_secondary_osc_enable)
		else $error("secondary oscillator not enabled");
	chk_secondary_osc_drive: assert property (r0 && o_rdata[2] && i_secondary_input_cfg |-> ##[0:2] o_secondary_high_power)
		else $error("high power secondary not selected");
	cover property (o_switch_busy);
	cover property (r0 && o_rdata[3]);
	cover property (r1 && o_cpu_doze_ratio == 3'h7);
endmodule

bind oscdz_osc_ctrl oscdz_chk u_chk (.i_clk, .i_reset, .i_addr, .i_read, .o_rdata, .i_secondary_input_cfg,
	.o_current_source_sel, .o_secondary_osc_enable, .o_secondary_high_power, .o_cpu_doze_ratio,
	.o_fast_rc_postscale, .o_fast_rc_trim, .o_switch_busy);

// ==== bench/test_oscdz_osc_ctrl.sv ====
// self-checking bench for the oscillator control block
module test_oscdz_osc_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_reset, i_write, i_read, i_switch_monitor_cfg_n, i_failsafe_monitor_cfg_n;
	logic        i_secondary_input_cfg, i_secondary_power_cfg, i_pll_locked, i_failsafe_monitor_fail;
	logic        i_new_source_ready, i_new_source_clk, i_secondary_required, i_interrupt;
	logic [1:0]  i_addr;
	logic [2:0]  i_initial_source_cfg, o_current_source_sel, o_cpu_doze_ratio, o_fast_rc_postscale;
	logic [5:0]  o_fast_rc_trim;
	logic [31:0] i_wdata, o_rdata, seed, d;
	logic        o_secondary_osc_enable, o_secondary_high_power, o_fast_rc_divided_on;
	logic        o_slow_fast_rc_divided_on, o_switch_busy, rd_d;
	logic [31:0] exp_q[$];
	int          bad_count, compares;
	oscdz_osc_ctrl u_dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .i_initial_source_cfg,
		.i_switch_monitor_cfg_n, .i_failsafe_monitor_cfg_n, .i_secondary_input_cfg, .i_secondary_power_cfg,
		.i_pll_locked, .i_failsafe_monitor_fail, .i_new_source_ready, .i_new_source_clk, .i_secondary_required,
		.i_interrupt, .o_current_source_sel, .o_secondary_osc_enable, .o_secondary_high_power, .o_cpu_doze_ratio,
		.o_fast_rc_postscale, .o_fast_rc_divided_on, .o_slow_fast_rc_divided_on, .o_fast_rc_trim, .o_switch_busy);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= v;
		i_write <= 1'b1;
		i_read  <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr  <= a;
		i_read  <= 1'b1;
		i_write <= 1'b0;
		exp_q.push_back(e);
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clk);
			i_write <= 1'b0;
			i_read  <= 1'b0;
		end
	endtask
	// two-write key on the high lane, then the committing write
	task automatic setnext(input logic [2:0] s);
		wr(2'h0, 32'h17800);
		wr(2'h0, 32'h19A00);
		wr(2'h0, {16'h0001, 5'h00, s, 8'h00});
	endtask
	task automatic lowwr(input logic [7:0] v);
		wr(2'h0, 32'h20046);
		wr(2'h0, 32'h20057);
		wr(2'h0, {24'h200, v});
		idle(1);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge i_clk);
			i_new_source_clk <= 1'b1;
			repeat (4) @(posedge i_clk);
			i_new_source_clk <= 1'b0;
		end
	endtask
	task automatic waitcur(input logic [2:0] s);
		for (int k = 0; k < 40 && o_current_source_sel !== s; k++)
			@(posedge i_clk);
		if (o_current_source_sel !== s) begin
			bad_count++;
			stop_test();
		end
	endtask
	task automatic irq();
		i_interrupt <= 1'b1;
		idle(4);
		i_interrupt <= 1'b0;
		idle(4);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		stop_test();
	end
	// read data stand only in the cycle after the strobe
	always @(posedge i_clk) begin
		if (rd_d === 1'b1)
			cmp("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_0000, o_rdata);
		rd_d <= i_read;
	end
	initial begin
		{i_write, i_read, i_addr, i_wdata, i_pll_locked, i_failsafe_monitor_fail, i_interrupt} = '0;
		{i_new_source_ready, i_new_source_clk, i_secondary_required, i_secondary_power_cfg} = '0;
		{i_switch_monitor_cfg_n, i_failsafe_monitor_cfg_n} = 2'b00;
		i_secondary_input_cfg = 1'b1;
		i_initial_source_cfg = 3'h7;
		i_reset = 1'b1;
		seed = 32'd40728;
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		idle(3);
		cmp("current source", 32'h7, 32'(o_current_source_sel));
		cmp("divided on", 32'h1, 32'(o_fast_rc_divided_on));
		rd(2'h0, 32'h7700);
		rd(2'h1, 32'h3100);
		rd(2'h2, 32'h0);
		wr(2'h3, 32'hFFFF);
		wr(2'h0, 32'h10000);
		rd(2'h3, 32'h0);
		rd(2'h0, 32'h7700);
		i_secondary_required <= 1'b1;
		idle(4);
		cmp("secondary_osc enable", 32'h1, 32'(o_secondary_osc_enable));
		i_secondary_required <= 1'b0;
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			d = (seed & 32'hFFFF_80FF) | {17'h0, k[2:0], 1'b1, k[2:0], 8'h00};
			wr(2'h1, d);
			rd(2'h1, d & 32'hFF00);
			idle(2);
			cmp("doze ratio", 32'(k[2:0]), 32'(o_cpu_doze_ratio));
			cmp("postscale", 32'(k[2:0]), 32'(o_fast_rc_postscale));
		end
		wr(2'h1, 32'hB900);
		idle(1);
		irq();
		rd(2'h1, 32'hB100);
		idle(2);
		cmp("doze ratio", 32'h0, 32'(o_cpu_doze_ratio));
		wr(2'h1, 32'h3900);
		idle(1);
		irq();
		rd(2'h1, 32'h3900);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			wr(2'h2, seed);
			rd(2'h2, seed & 32'h3F);
			idle(2);
			cmp("trim", seed & 32'h3F, 32'(o_fast_rc_trim));
		end
		$display("divider and trim tests done");
		setnext(3'h0);
		lowwr(8'h07);
		idle(5);
		rd(2'h0, 32'h7007);
		idle(2);
		cmp("busy", 32'h1, 32'(o_switch_busy));
		cmp("high power", 32'h1, 32'(o_secondary_high_power));
		i_new_source_ready <= 1'b1;
		idle(6);
		pulses(9);
		cmp("current source", 32'h7, 32'(o_current_source_sel));
		pulses(1);
		waitcur(3'h0);
		rd(2'h0, 32'h0006);
		lowwr(8'h07);
		idle(8);
		rd(2'h0, 32'h0006);
		i_pll_locked <= 1'b1;
		setnext(3'h3);
		lowwr(8'h07);
		idle(6);
		pulses(10);
		waitcur(3'h3);
		idle(4);
		rd(2'h0, 32'h3326);
		i_pll_locked <= 1'b0;
		idle(5);
		rd(2'h0, 32'h3306);
		i_pll_locked <= 1'b1;
		$display("switch tests done");
		i_failsafe_monitor_fail <= 1'b1;
		idle(4);
		i_failsafe_monitor_fail <= 1'b0;
		idle(4);
		rd(2'h0, 32'h332E);
		lowwr(8'h0E);
		rd(2'h0, 32'h332E);
		lowwr(8'h06);
		rd(2'h0, 32'h3326);
		lowwr(8'h86);
		setnext(3'h0);
		idle(1);
		rd(2'h0, 32'h33A6);
		idle(3);
		$display("fail and lock tests done");
		// restart with the monitor off and the slow fast RC configured
		{i_failsafe_monitor_cfg_n, i_initial_source_cfg} <= 4'hE;
		i_reset <= 1'b1;
		idle(1);
		i_reset <= 1'b0;
		idle(3);
		cmp("slow divided on", 32'h1, 32'(o_slow_fast_rc_divided_on));
		lowwr(8'h80);
		setnext(3'h0);
		idle(1);
		rd(2'h0, 32'h6080);
		idle(3);
		// restart with switching off and a digital secondary input
		{i_switch_monitor_cfg_n, i_secondary_input_cfg} <= 2'b10;
		i_reset <= 1'b1;
		idle(1);
		i_reset <= 1'b0;
		idle(3);
		setnext(3'h0);
		lowwr(8'h05);
		idle(2);
		rd(2'h0, 32'h6604);
		idle(2);
		cmp("high power", 32'h0, 32'(o_secondary_high_power));
		$display("restart tests done");
		stop_test();
	end
endmodule
